// ---- hdl/tmch_pkg.sv ----
// Purpose: shared constants and types of the tag memory command handler
// Assumes: reader framing, parity and CRC are handled outside this block
// Notes: page numbers and codes are eight and four bits wide
package tmch_pkg;
	// command opcodes and fixed arguments
	localparam logic [7:0] OP_MULTI_READ = 8'h3A;
	localparam logic [7:0] OP_PAGE_WRITE = 8'hA2;
	localparam logic [7:0] OP_LEGACY_WRITE = 8'hA0;
	localparam logic [7:0] OP_COUNTER_READ = 8'h39;
	localparam logic [7:0] COUNTER_ARG = 8'h02;
	// four-bit answers
	localparam logic [3:0] ANS_ACK = 4'hA;
	localparam logic [3:0] NAK_ARG = 4'h0;
	localparam logic [3:0] NAK_CRC = 4'h1;
	localparam logic [3:0] NAK_AUTH_OVF = 4'h4;
	localparam logic [3:0] NAK_WRITE = 4'h5;
	// memory layout of the smallest size variant
	localparam logic [7:0] LAST_PAGE = 8'h2C;
	localparam logic [7:0] FIRST_WRITE_PAGE = 8'h02;
	localparam logic [7:0] STATIC_LOCK_PAGE = 8'h02;
	localparam logic [7:0] CAP_CONTAINER_PAGE = 8'h03;
	localparam logic [7:0] DYN_LOCK_PAGE = 8'h28;
	localparam logic [7:0] STATIC_LOCK_LAST = 8'h0F;
	localparam logic [7:0] DYN_LOCK_FIRST = 8'h10;
	// frame lengths in bytes, CRC excluded
	localparam logic [4:0] MULTI_READ_LEN = 5'd3;
	localparam logic [4:0] PAGE_WRITE_LEN = 5'd6;
	localparam logic [4:0] SHORT_CMD_LEN = 5'd2;
	localparam logic [4:0] LEGACY_DATA_LEN = 5'd16;
	localparam int RX_BYTES = 16;
	localparam logic [1:0] COUNTER_LAST_BYTE = 2'd2;
	// timing
	localparam int FDT_N = 9;
	localparam int FDT_MIN_NS = 87000;
	localparam int CLK_SYS_NS = 5;
	localparam int FDT_CYCLES = (FDT_MIN_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int READ_TIMEOUT_MS = 5;
	localparam int WRITE_TIMEOUT_MS = 10;
	// register port
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_COUNTER = 8'h08;
	localparam int CFG_PROT_START_LSB = 0;
	localparam int CFG_READ_PROT_BIT = 8;
	localparam int CFG_CNT_PW_BIT = 9;
	localparam int CFG_AUTH_BIT = 10;
	localparam int CFG_CFG_LOCK_BIT = 11;
	localparam logic [11:0] CFG_RESET = 12'h0FF;
	localparam logic [23:0] COUNTER_RESET = 24'h000000;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_SEND = 2'b11,
		ST_ACKW = 2'b10
	} tmch_state_type;
endpackage : tmch_pkg

// ---- hdl/tmch_top.sv ----
// Purpose: command handler of a contactless memory tag
// Assumes: frames arrive on clk_link with CRC already checked; CRC of answers is added outside
// Notes: one frame is handled at a time; bytes arriving while busy are dropped
// Notes on behaviour
// - multi-page read returns every page start to end
// - read start page above last page gets NAK
// - unauthenticated read at protected page gets NAK
// - post_login_state state ignores password access protection
// - password and its acknowledge read as zeros
// - answer waits frame delay; reader allows timeouts
// - page write stores four bytes in page
// - writes accept pages two to last only
// - locked pages are never reprogrammed; lock pages are overwritten whole, so lock bits can be cleared
// - unauthenticated write at protected page gets NAK
// - lock and container pages written tear-safe
// - legacy write stores bytes zero to three
// - counter read returns three counter bytes
// - protected counter needs post_login_state state
// - four-bit answers use the fixed code set
//
// The implementer's own choices: the plain strobed port and the register addresses.
module tmch_top #(
	parameter int FDT_CYCLES = tmch_pkg::FDT_CYCLES,
	parameter logic [7:0] LAST_PAGE = tmch_pkg::LAST_PAGE,
	parameter logic [7:0] DYN_LOCK_PAGE = tmch_pkg::DYN_LOCK_PAGE
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic clk_link,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_end,
	input wire logic rx_err,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_nibble,
	output logic tx_last,
	input wire logic tx_ready
);
	import tmch_pkg::*;

	localparam int NUM_PAGES = int'(LAST_PAGE) + 1;
	localparam logic [7:0] PWD_PAGE = LAST_PAGE - 8'h01;
	localparam logic [7:0] PW_ACK_PAGE = LAST_PAGE;

	typedef struct packed {
		logic [RX_BYTES-1:0][7:0] buf_b;
		logic [4:0] len;
		logic err;
		logic fresh;
		logic rx_tog;
		logic [1:0] fack_sync;
		logic [1:0] req_sync;
		logic ack_tog;
		logic tx_valid;
		logic [7:0] tx_data;
		logic tx_last;
		logic tx_nibble;
	} tmch_link_type;

	typedef struct packed {
		tmch_state_type st;
		logic [NUM_PAGES-1:0][31:0] mem;
		logic [23:0] counter;
		logic [11:0] cfg;
		logic [31:0] rdata;
		logic [1:0] rx_sync;
		logic fack;
		logic legacy_pend;
		logic [7:0] legacy_page;
		logic [3:0] code;
		logic nibble;
		logic is_counter;
		logic [7:0] page;
		logic [7:0] end_page;
		logic [1:0] bsel;
		logic [15:0] fdt_cnt;
		logic [7:0] hold_data;
		logic hold_last;
		logic hold_nibble;
		logic req_tog;
		logic [1:0] ack_sync;
	} tmch_sys_type;

	tmch_link_type lk_reg, lk_next;
	tmch_sys_type sy_reg, sy_next;

	// lock decode: static bits cover pages 3..15, dynamic pairs from page 16
	function automatic logic page_locked(input logic [7:0] pg, input logic [15:0] slock,
		input logic [15:0] dlock, input logic cfg_lock);
		logic [7:0] rel;
		rel = 8'(pg - DYN_LOCK_FIRST) >> 1;
		if (pg >= CAP_CONTAINER_PAGE && pg <= STATIC_LOCK_LAST) begin
			return slock[pg[3:0]];
		end
		if (pg >= DYN_LOCK_FIRST && pg < DYN_LOCK_PAGE) begin
			return dlock[rel[3:0]];
		end
		if (pg >= DYN_LOCK_PAGE) begin
			return cfg_lock;
		end
		return 1'b0;
	endfunction : page_locked

	// page range, lock and password checks shared by both write commands
	function automatic logic write_ok(input logic [7:0] pg, input tmch_sys_type s);
		logic auth;
		logic [15:0] slock;
		logic [15:0] dlock;
		auth = s.cfg[CFG_AUTH_BIT];
		slock = s.mem[STATIC_LOCK_PAGE][31:16];
		dlock = s.mem[DYN_LOCK_PAGE][15:0];
		if (pg < FIRST_WRITE_PAGE || pg > LAST_PAGE) begin
			return 1'b0;
		end
		if (page_locked(pg, slock, dlock, s.cfg[CFG_CFG_LOCK_BIT])) begin
			return 1'b0;
		end
		if (!auth && pg >= s.cfg[CFG_PROT_START_LSB +: 8]) begin
			return 1'b0;
		end
		return 1'b1;
	endfunction : write_ok

	// link side: gather a frame, hand it over, present answer bytes
	always_comb begin
		logic busy;
		lk_next = lk_reg;
		busy = lk_reg.rx_tog != lk_reg.fack_sync[1];
		lk_next.fack_sync = {lk_reg.fack_sync[0], sy_reg.fack};
		lk_next.req_sync = {lk_reg.req_sync[0], sy_reg.req_tog};
		if (rx_valid && !busy) begin
			if (lk_reg.fresh) begin
				lk_next.buf_b[0] = rx_data;
				lk_next.len = 5'd1;
				lk_next.fresh = 1'b0;
			end else if (lk_reg.len < LEGACY_DATA_LEN) begin
				lk_next.buf_b[lk_reg.len[3:0]] = rx_data;
				lk_next.len = lk_reg.len + 5'd1;
			end else begin
				// oversize frame fails every length check
				lk_next.len = LEGACY_DATA_LEN + 5'd1;
			end
		end
		if (rx_end && !busy) begin
			if (lk_reg.fresh) begin
				lk_next.len = 5'd0;
			end
			lk_next.err = rx_err;
			lk_next.fresh = 1'b1;
			lk_next.rx_tog = !lk_reg.rx_tog;
		end
		if (lk_reg.tx_valid && tx_ready) begin
			lk_next.tx_valid = 1'b0;
			lk_next.ack_tog = !lk_reg.ack_tog;
		end else if (!lk_reg.tx_valid && lk_reg.req_sync[1] != lk_reg.ack_tog) begin
			// hold registers stay still until the acknowledge toggles back
			lk_next.tx_valid = 1'b1;
			lk_next.tx_data = sy_reg.hold_data;
			lk_next.tx_last = sy_reg.hold_last;
			lk_next.tx_nibble = sy_reg.hold_nibble;
		end
	end

	always_ff @(posedge clk_link or negedge resetn) begin
		if (!resetn) begin
			lk_reg <= '0;
			lk_reg.fresh <= 1'b1;
		end else begin
			lk_reg <= lk_next;
		end
	end

	// system side: decode, check, wait the frame delay, stream the answer
	always_comb begin
		logic [7:0] op;
		logic [7:0] a1;
		logic [7:0] a2;
		logic [7:0] pstart;
		logic auth;
		logic rd_prot;
		logic [7:0] pg_byte;
		sy_next = sy_reg;
		op = lk_reg.buf_b[0];
		a1 = lk_reg.buf_b[1];
		a2 = lk_reg.buf_b[2];
		pstart = sy_reg.cfg[CFG_PROT_START_LSB +: 8];
		auth = sy_reg.cfg[CFG_AUTH_BIT];
		rd_prot = sy_reg.cfg[CFG_READ_PROT_BIT] && !auth;
		pg_byte = 8'h00;
		sy_next.rx_sync = {sy_reg.rx_sync[0], lk_reg.rx_tog};
		sy_next.ack_sync = {sy_reg.ack_sync[0], lk_reg.ack_tog};
		sy_next.rdata = 32'h00000000;
		if (reg_rd) begin
			case (reg_addr)
				REG_CFG: sy_next.rdata = {20'h00000, sy_reg.cfg};
				REG_STATUS: sy_next.rdata = {24'h000000, sy_reg.legacy_pend, sy_reg.nibble,
					sy_reg.st, sy_reg.code};
				REG_COUNTER: sy_next.rdata = {8'h00, sy_reg.counter};
				default: sy_next.rdata = 32'h00000000;
			endcase
		end
		if (reg_wr && reg_addr == REG_CFG) begin
			sy_next.cfg = reg_wdata[11:0];
		end
		// one-way counter: software may only step it up, it saturates
		if (reg_wr && reg_addr == REG_COUNTER && sy_reg.counter != 24'hFFFFFF) begin
			sy_next.counter = sy_reg.counter + 24'h000001;
		end
		case (sy_reg.st)
			ST_IDLE: begin
				if (sy_reg.rx_sync[1] != sy_reg.fack) begin
					sy_next.st = ST_WAIT;
					sy_next.fdt_cnt = 16'h0000;
					sy_next.nibble = 1'b1;
					sy_next.is_counter = 1'b0;
					sy_next.bsel = 2'd0;
					sy_next.code = NAK_ARG;
					if (lk_reg.err) begin
						sy_next.code = NAK_CRC;
						sy_next.legacy_pend = 1'b0;
					end else if (sy_reg.legacy_pend) begin
						sy_next.legacy_pend = 1'b0;
						if (lk_reg.len == LEGACY_DATA_LEN) begin
							// whole word in one cycle after a checked frame: no torn page
							sy_next.mem[sy_reg.legacy_page] = {lk_reg.buf_b[3], lk_reg.buf_b[2],
								lk_reg.buf_b[1], lk_reg.buf_b[0]};
							sy_next.code = ANS_ACK;
						end
					end else if (op == OP_MULTI_READ && lk_reg.len == MULTI_READ_LEN) begin
						if (a1 <= LAST_PAGE && a2 <= LAST_PAGE && a2 >= a1
							&& !(rd_prot && a2 >= pstart)) begin
							sy_next.nibble = 1'b0;
							sy_next.page = a1;
							sy_next.end_page = a2;
						end
					end else if (op == OP_PAGE_WRITE && lk_reg.len == PAGE_WRITE_LEN) begin
						if (write_ok(a1, sy_reg)) begin
							sy_next.mem[a1] = {lk_reg.buf_b[5], lk_reg.buf_b[4],
								lk_reg.buf_b[3], lk_reg.buf_b[2]};
							sy_next.code = ANS_ACK;
						end
					end else if (op == OP_LEGACY_WRITE && lk_reg.len == SHORT_CMD_LEN) begin
						if (write_ok(a1, sy_reg)) begin
							sy_next.legacy_pend = 1'b1;
							sy_next.legacy_page = a1;
							sy_next.code = ANS_ACK;
						end
					end else if (op == OP_COUNTER_READ && lk_reg.len == SHORT_CMD_LEN) begin
						if (a1 == COUNTER_ARG && !(sy_reg.cfg[CFG_CNT_PW_BIT] && !auth)) begin
							sy_next.nibble = 1'b0;
							sy_next.is_counter = 1'b1;
						end
					end
				end
			end
			ST_WAIT: begin
				sy_next.fdt_cnt = sy_reg.fdt_cnt + 16'h0001;
				if (sy_reg.fdt_cnt >= 16'(FDT_CYCLES - 1)) begin
					sy_next.st = ST_SEND;
				end
			end
			ST_SEND: begin
				sy_next.req_tog = !sy_reg.req_tog;
				sy_next.st = ST_ACKW;
				if (sy_reg.nibble) begin
					sy_next.hold_data = {4'h0, sy_reg.code};
					sy_next.hold_nibble = 1'b1;
					sy_next.hold_last = 1'b1;
				end else if (sy_reg.is_counter) begin
					sy_next.hold_data = sy_reg.counter[sy_reg.bsel*8 +: 8];
					sy_next.hold_nibble = 1'b0;
					sy_next.hold_last = sy_reg.bsel == COUNTER_LAST_BYTE;
					sy_next.bsel = sy_reg.bsel + 2'd1;
				end else begin
					if (sy_reg.page != PWD_PAGE && sy_reg.page != PW_ACK_PAGE) begin
						pg_byte = sy_reg.mem[sy_reg.page][sy_reg.bsel*8 +: 8];
					end
					sy_next.hold_data = pg_byte;
					sy_next.hold_nibble = 1'b0;
					sy_next.hold_last = sy_reg.page == sy_reg.end_page && sy_reg.bsel == 2'd3;
					sy_next.bsel = sy_reg.bsel + 2'd1;
					if (sy_reg.bsel == 2'd3) begin
						sy_next.page = sy_reg.page + 8'h01;
					end
				end
			end
			ST_ACKW: begin
				if (sy_reg.ack_sync[1] == sy_reg.req_tog) begin
					if (sy_reg.hold_last) begin
						sy_next.st = ST_IDLE;
						sy_next.fack = sy_reg.rx_sync[1];
					end else begin
						sy_next.st = ST_SEND;
					end
				end
			end
			default: begin
				sy_next.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sy_reg <= '0;
			sy_reg.st <= ST_IDLE;
			sy_reg.cfg <= CFG_RESET;
			sy_reg.counter <= COUNTER_RESET;
		end else begin
			sy_reg <= sy_next;
		end
	end

	assign reg_rdata = sy_reg.rdata;
	assign tx_valid = lk_reg.tx_valid;
	assign tx_data = lk_reg.tx_data;
	assign tx_nibble = lk_reg.tx_nibble;
	assign tx_last = lk_reg.tx_last;

endmodule : tmch_top

// ---- verification/tmch_chk.sv ----
// Purpose: port checker of the tag memory command handler
// Assumes: the reader sends no frame while an answer is pending
// Notes: link figures are counted on clk_link, the frame delay scaled by 5/12
module tmch_chk #(
	parameter int FDT_CYCLES = 20
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic clk_link,
	input wire logic rx_end,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_nibble,
	input wire logic tx_last,
	input wire logic tx_ready
);
	localparam int FDT_LINK = FDT_CYCLES * 5 / 12;
	logic in_frame;
	logic pend;
	logic [7:0] nbytes;
	int since_end;
	sequence acc_s;
		tx_valid && tx_ready;
	endsequence
	// counters live on the link clock so no crossing blurs the figures
	always_ff @(posedge clk_link or negedge resetn) begin
		if (!resetn) begin
			in_frame <= 1'b0;
			pend <= 1'b0;
			nbytes <= 8'h00;
			since_end <= 0;
		end else begin
			if (tx_valid && tx_ready) begin
				in_frame <= !tx_last;
				nbytes <= tx_last ? 8'h00 : nbytes + 8'h01;
			end
			if (tx_valid)
				pend <= 1'b0;
			if (rx_end)
				pend <= 1'b1;
			since_end <= rx_end ? 0 : since_end + 1;
		end
	end
	rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data off slot");
	item_hold_a: assert property (@(posedge clk_link) disable iff (!resetn)
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("item dropped early");
	nib_code_a: assert property (@(posedge clk_link) disable iff (!resetn)
		tx_valid && tx_nibble |-> tx_last && tx_data inside {8'h0A, 8'h00, 8'h01})
		else $error("bad short code");
	nak_whole_a: assert property (@(posedge clk_link) disable iff (!resetn)
		tx_valid && in_frame |-> !tx_nibble) else $error("code after data");
	fdt_min_a: assert property (@(posedge clk_link) disable iff (!resetn)
		$rose(tx_valid) && !in_frame |-> since_end >= FDT_LINK) else $error("answer too early");
	ans_bound_a: assert property (@(posedge clk_link) disable iff (!resetn)
		pend |-> since_end <= FDT_LINK + 60) else $error("answer too late");
	item_gap_a: assert property (@(posedge clk_link) disable iff (!resetn)
		acc_s |=> !tx_valid) else $error("item repeated");
	ans_len_a: assert property (@(posedge clk_link) disable iff (!resetn)
		acc_s ##0 (tx_last && !tx_nibble) |-> nbytes == 8'h02 || nbytes[1:0] == 2'b11)
		else $error("bad answer length");
endmodule : tmch_chk
bind tmch_top tmch_chk #(.FDT_CYCLES(FDT_CYCLES)) chk_u (.clk_sys, .resetn, .reg_rd,
	.reg_rdata, .clk_link, .rx_end, .tx_valid, .tx_data, .tx_nibble, .tx_last, .tx_ready);

// ---- verification/tmch_reader_model.sv ----
// Purpose: reader model that frames commands and collects answers
// Assumes: one frame outstanding at a time
// Notes: slow mode raises ready on one link cycle of four
module tmch_reader_model (
	input wire logic clk_link,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	output logic rx_err,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_nibble,
	input wire logic tx_last,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got_q[$];
	logic got_nib;
	logic done = 1'b0;
	logic slow = 1'b0;
	logic [1:0] tick = 2'd0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h5A;
		rx_end = 1'b0;
		rx_err = 1'b0;
	end
	task automatic send_frame(input logic [7:0] b[$], input logic err);
		foreach (b[i]) begin
			@(posedge clk_link);
			rx_valid <= 1'b1;
			rx_data <= b[i];
		end
		@(posedge clk_link);
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
		rx_end <= 1'b1;
		rx_err <= err;
		@(posedge clk_link);
		rx_end <= 1'b0;
		rx_err <= 1'b0;
	endtask : send_frame
	always @(posedge clk_link) begin
		tick <= tick + 2'd1;
		tx_ready <= !slow || tick == 2'd3;
		// a new frame forgets the previous answer's end mark
		if (rx_end)
			done <= 1'b0;
		if (tx_valid && tx_ready) begin
			got_q.push_back(tx_data);
			got_nib <= tx_nibble;
			done <= tx_last;
		end
	end
endmodule : tmch_reader_model

// ---- verification/tmch_top_tb.sv ----
// Purpose: self-checking bench of the tag memory command handler
// Assumes: frame delay shortened to 20 cycles
// Notes: each scenario task sends frames and judges the answers
module tmch_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tmch_pkg::*;
	localparam int FDT_SIM = 20;
	logic clk_sys = 1'b0;
	logic clk_link = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic rx_valid, rx_end, rx_err, tx_valid, tx_nibble, tx_last, tx_ready;
	logic [7:0] rx_data, tx_data;
	int n_mismatch = 0;
	int tests_run = 0;
	always #2.5 clk_sys = ~clk_sys;
	always #6 clk_link = ~clk_link;
	tmch_top #(.FDT_CYCLES(FDT_SIM)) dut_u (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .clk_link, .rx_valid, .rx_data, .rx_end, .rx_err, .tx_valid,
		.tx_data, .tx_nibble, .tx_last, .tx_ready);
	tmch_reader_model rdr (.clk_link, .rx_valid, .rx_data, .rx_end, .rx_err, .tx_valid,
		.tx_data, .tx_nibble, .tx_last, .tx_ready);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		if (n_mismatch == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	task automatic reg_put(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_put
	task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, e);
	endtask : reg_chk
	// the bound on each wait stands in for the reader's timeout
	task automatic xfer(input logic [7:0] f[$], input logic err, input logic [7:0] e[$],
		input logic nib);
		int n;
		n = 0;
		rdr.got_q.delete();
		rdr.send_frame(f, err);
		while (!tx_valid && n < 999) begin
			@(posedge clk_sys);
			n++;
		end
		check(n >= FDT_SIM - 3, 1);
		while (!rdr.done && n < 2999) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 2999) begin
			n_mismatch++;
			complete_run;
		end else begin
			check(rdr.got_q.size(), e.size());
			foreach (e[i]) check(rdr.got_q[i], e[i]);
			check(rdr.got_nib, nib);
			repeat (8) @(posedge clk_link);
		end
	endtask : xfer
	task automatic ans(input logic [7:0] f[$], input logic [3:0] c);
		xfer(f, 1'b0, {8'(c)}, 1'b1);
	endtask : ans
	task automatic t_misc;
		reg_chk(REG_CFG, 32'h0000_00FF);
		reg_chk(8'h0C, 32'h0);
		xfer({OP_MULTI_READ, 8'h00, 8'h00}, 1'b1, {8'(NAK_CRC)}, 1'b1);
		ans({8'h55, 8'h00}, NAK_ARG);
	endtask : t_misc
	task automatic t_write_read;
		ans({OP_PAGE_WRITE, 8'h05, 8'h11, 8'h22, 8'h33, 8'h44}, ANS_ACK);
		rdr.slow = 1'b1;
		xfer({OP_MULTI_READ, 8'h05, 8'h06}, 1'b0, {8'h11, 8'h22, 8'h33, 8'h44, 8'h00,
			8'h00, 8'h00, 8'h00}, 1'b0);
		rdr.slow = 1'b0;
	endtask : t_write_read
	task automatic t_range;
		logic [7:0] p[3] = '{8'h00, 8'h01, 8'h2D};
		ans({OP_MULTI_READ, 8'h2D, 8'h2D}, NAK_ARG);
		foreach (p[i]) begin
			ans({OP_PAGE_WRITE, p[i], 8'h01, 8'h01, 8'h01, 8'h01}, NAK_ARG);
			ans({OP_LEGACY_WRITE, p[i]}, NAK_ARG);
		end
		ans({OP_PAGE_WRITE, 8'h2B, 8'h5A, 8'h5A, 8'h5A, 8'h5A}, ANS_ACK);
		xfer({OP_MULTI_READ, 8'h2B, 8'h2C}, 1'b0, {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00}, 1'b0);
	endtask : t_range
	task automatic t_protect;
		reg_put(REG_CFG, 32'h0000_0110);
		ans({OP_MULTI_READ, 8'h0E, 8'h10}, NAK_ARG);
		ans({OP_PAGE_WRITE, 8'h10, 8'h77, 8'h77, 8'h77, 8'h77}, NAK_ARG);
		ans({OP_LEGACY_WRITE, 8'h10}, NAK_ARG);
		reg_put(REG_CFG, 32'h0000_0510);
		xfer({OP_MULTI_READ, 8'h10, 8'h10}, 1'b0, {8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
		ans({OP_PAGE_WRITE, 8'h10, 8'h77, 8'h77, 8'h77, 8'h77}, ANS_ACK);
		reg_put(REG_CFG, 32'h0000_00FF);
	endtask : t_protect
	task automatic t_locks;
		ans({OP_PAGE_WRITE, 8'h02, 8'h00, 8'h00, 8'h20, 8'h00}, ANS_ACK);
		ans({OP_PAGE_WRITE, 8'h05, 8'h99, 8'h99, 8'h99, 8'h99}, NAK_ARG);
		xfer({OP_MULTI_READ, 8'h05, 8'h05}, 1'b0, {8'h11, 8'h22, 8'h33, 8'h44}, 1'b0);
		ans({OP_PAGE_WRITE, DYN_LOCK_PAGE, 8'h01, 8'h00, 8'h00, 8'h00}, ANS_ACK);
		ans({OP_PAGE_WRITE, 8'h11, 8'h99, 8'h99, 8'h99, 8'h99}, NAK_ARG);
		reg_put(REG_CFG, 32'h0000_08FF);
		ans({OP_LEGACY_WRITE, 8'h29}, NAK_ARG);
		reg_put(REG_CFG, 32'h0000_00FF);
	endtask : t_locks
	task automatic t_legacy;
		logic [7:0] d[$] = {8'h01, 8'h02, 8'h03, 8'h04};
		repeat (12) d.push_back(8'h00);
		ans({OP_LEGACY_WRITE, 8'h07}, ANS_ACK);
		ans(d, ANS_ACK);
		ans({OP_LEGACY_WRITE, 8'h07}, ANS_ACK);
		ans({8'h09, 8'h09}, NAK_ARG);
		xfer({OP_MULTI_READ, 8'h07, 8'h07}, 1'b0, {8'h01, 8'h02, 8'h03, 8'h04}, 1'b0);
	endtask : t_legacy
	task automatic t_counter;
		reg_chk(REG_COUNTER, 32'h0);
		reg_put(REG_COUNTER, 32'h1);
		reg_put(REG_COUNTER, 32'h1);
		xfer({OP_COUNTER_READ, COUNTER_ARG}, 1'b0, {8'h02, 8'h00, 8'h00}, 1'b0);
		ans({OP_COUNTER_READ, 8'h01}, NAK_ARG);
		reg_put(REG_CFG, 32'h0000_02FF);
		ans({OP_COUNTER_READ, COUNTER_ARG}, NAK_ARG);
		reg_put(REG_CFG, 32'h0000_06FF);
		xfer({OP_COUNTER_READ, COUNTER_ARG}, 1'b0, {8'h02, 8'h00, 8'h00}, 1'b0);
	endtask : t_counter
	initial begin
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_misc;
		t_write_read;
		t_range;
		t_protect;
		t_locks;
		t_legacy;
		t_counter;
		complete_run;
	end
endmodule : tmch_top_tb
